// file: src/deep_sleep_clock_gate_reg1.sv
// Purpose: Peripheral clock gating, bank 1, with AHB-Lite register slave
// Assumes: Mode and unit access inputs synchronous to hclk
// Notes:   Reads take one wait state, writes none
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module deep_sleep_clock_gate_reg1 import gate_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output      logic [31:0] hrdata,
	output      logic        hreadyout,
	output      logic        hresp,
	input  wire logic        sleep_mode,
	input  wire logic        deep_sleep_mode,
	input  wire logic [31:0] unit_access,
	output      logic [31:0] unit_clk_en,
	output      logic        bus_fault,
	output      logic        irq
);
	// ************************************************************
	// Storage
	// ************************************************************
	logic [31:0]          run_peripheral_gate_1;
	logic [31:0]          sleep_peripheral_gate_1;
	logic [31:0]          deep_sleep_peripheral_gate_1;
	logic                 auto_gating_select;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [IRQ_WIDTH-1:0] events;
	logic [31:0]          fault_seen;
	mode_t                mode;
	mode_t                next_mode;
	logic                 ph_valid;
	logic                 ph_write;
	logic [11:0]          ph_addr;
	logic                 rd_wait;
	logic [31:0]          next_rdata;
	logic                 addr_phase;
	logic                 wr_now;

	gate_if gi ();

	function automatic logic wr_hit(input logic en, input logic [11:0] a,
		input logic [11:0] ofs);
		return en && (a == ofs);
	endfunction

	// ************************************************************
	// Submodules
	// ************************************************************
	gate_select u_select (
		.hclk    (hclk),
		.hresetn (hresetn),
		.gi      (gi.sel)
	);

	fault_check u_check (
		.hclk    (hclk),
		.hresetn (hresetn),
		.gi      (gi.chk)
	);

	assign gi.run_gate    = run_peripheral_gate_1;
	assign gi.sleep_gate  = sleep_peripheral_gate_1;
	assign gi.deep_gate   = deep_sleep_peripheral_gate_1;
	assign gi.auto_gating = auto_gating_select;
	assign gi.mode        = mode;
	assign gi.access      = unit_access;
	assign unit_clk_en    = gi.clk_en;
	assign bus_fault      = gi.fault;

	// ************************************************************
	// Bus phases
	// ************************************************************
	assign addr_phase = hsel && hready && htrans[HTRANS_ACT_BIT];
	assign wr_now     = ph_valid && ph_write && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 12'h000;
		end else if (hready) begin
			ph_valid <= addr_phase;
			ph_write <= hwrite;
			ph_addr  <= haddr[11:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait   <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			rd_wait   <= addr_phase && !hwrite;
			hreadyout <= !(addr_phase && !hwrite);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ************************************************************
	// Gating registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deep_sleep_peripheral_gate_1 <= GATE_RESET;
		end else if (wr_hit(wr_now, ph_addr, DS_GATE_OFS)) begin
			deep_sleep_peripheral_gate_1 <= hwdata & GATE_WRITABLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_peripheral_gate_1 <= GATE_RESET;
		end else if (wr_hit(wr_now, ph_addr, RUN_GATE_OFS)) begin
			run_peripheral_gate_1 <= hwdata & GATE_WRITABLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_peripheral_gate_1 <= GATE_RESET;
		end else if (wr_hit(wr_now, ph_addr, SLEEP_GATE_OFS)) begin
			sleep_peripheral_gate_1 <= hwdata & GATE_WRITABLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_gating_select <= CFG_RESET;
		end else if (wr_hit(wr_now, ph_addr, CLK_CFG_OFS)) begin
			auto_gating_select <= hwdata[AUTO_GATING_BIT];
		end
	end

	// ************************************************************
	// Power mode
	// ************************************************************
	always_comb begin
		next_mode = mode_run;
		if (deep_sleep_mode) begin
			next_mode = mode_deep;
		end else if (sleep_mode) begin
			next_mode = mode_sleep;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= mode_run;
		end else begin
			mode <= next_mode;
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	always_comb begin
		events                = '0;
		events[IRQ_FAULT_BIT] = gi.fault;
		events[IRQ_ENTER_BIT] = (mode != mode_deep) && (next_mode == mode_deep);
		events[IRQ_EXIT_BIT]  = (mode == mode_deep) && (next_mode != mode_deep);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= IRQ_RESET;
		end else if (wr_hit(wr_now, ph_addr, IRQ_STATUS_OFS)) begin
			irq_status <= (irq_status & ~hwdata[IRQ_WIDTH-1:0]) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask <= IRQ_RESET;
		end else if (wr_hit(wr_now, ph_addr, IRQ_MASK_OFS)) begin
			irq_mask <= hwdata[IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_seen <= 32'h0000_0000;
		end else if (gi.fault) begin
			fault_seen <= gi.fault_vec;
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (ph_addr)
			DS_GATE_OFS: next_rdata = deep_sleep_peripheral_gate_1;
			RUN_GATE_OFS: next_rdata = run_peripheral_gate_1;
			SLEEP_GATE_OFS: next_rdata = sleep_peripheral_gate_1;
			CLK_CFG_OFS: next_rdata[AUTO_GATING_BIT] = auto_gating_select;
			IRQ_STATUS_OFS: next_rdata[IRQ_WIDTH-1:0] = irq_status;
			IRQ_MASK_OFS: next_rdata[IRQ_WIDTH-1:0] = irq_mask;
			FAULT_SEEN_OFS: next_rdata = fault_seen;
			GATE_STATE_OFS: next_rdata = gi.clk_en;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_wait) begin
			hrdata <= next_rdata;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	reset_clear_a: assert property (@(posedge hclk)
		!hresetn |-> (deep_sleep_peripheral_gate_1 == GATE_RESET) && (unit_clk_en == GATE_RESET))
		else $error("gating not cleared in reset");

	reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_wait && ph_addr == DS_GATE_OFS) |=> ((hrdata & ~GATE_WRITABLE) == 32'h0) && hreadyout)
		else $error("reserved bits read nonzero");

	comp_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_hit(wr_now, ph_addr, DS_GATE_OFS)
		|=> deep_sleep_peripheral_gate_1[COMPARATOR0_GATE_BIT] == $past(hwdata[COMPARATOR0_GATE_BIT]))
		else $error("comparator gate bit not stored");

	timer_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_hit(wr_now, ph_addr, DS_GATE_OFS)
		|=> deep_sleep_peripheral_gate_1[GP_A_BIT:GP_D_BIT] == $past(hwdata[GP_A_BIT:GP_D_BIT]))
		else $error("timer gate bits not stored");

	two_wire_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_hit(wr_now, ph_addr, DS_GATE_OFS)
		|=> deep_sleep_peripheral_gate_1[TWO_WIRE0_BIT] == $past(hwdata[TWO_WIRE0_BIT]))
		else $error("two-wire gate bit not stored");

	sync_serial_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_hit(wr_now, ph_addr, DS_GATE_OFS) |=> deep_sleep_peripheral_gate_1[
		SYNC_SERIAL1_BIT:SYNC_SERIAL0_BIT] == $past(hwdata[SYNC_SERIAL1_BIT:SYNC_SERIAL0_BIT]))
		else $error("sync serial gate bits not stored");

	async_serial_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_hit(wr_now, ph_addr, DS_GATE_OFS) |=> deep_sleep_peripheral_gate_1[
		ASYNC_SERIAL2_BIT:ASYNC_SERIAL0_BIT] == $past(hwdata[ASYNC_SERIAL2_BIT:ASYNC_SERIAL0_BIT]))
		else $error("async serial gate bits not stored");

	deep_apply_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == mode_deep && auto_gating_select) |=> unit_clk_en == $past(deep_sleep_peripheral_gate_1))
		else $error("deep register not applied");

	run_apply_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == mode_run) |=> unit_clk_en == $past(run_peripheral_gate_1))
		else $error("run register not applied");

	sleep_apply_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode == mode_sleep && auto_gating_select) |=> unit_clk_en == $past(sleep_peripheral_gate_1))
		else $error("sleep register not applied");

	auto_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(mode != mode_run && !auto_gating_select) |=> unit_clk_en == $past(run_peripheral_gate_1))
		else $error("sleep gating active without auto gating");

	gated_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
		((unit_access & GATE_WRITABLE & ~unit_clk_en) != 32'h0) |=> bus_fault)
		else $error("fault to unclocked unit missing");

	clocked_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		((unit_access & GATE_WRITABLE & ~unit_clk_en) == 32'h0) |=> !bus_fault)
		else $error("fault without unclocked access");

	switch_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(next_mode != mode) |-> ##1 $stable(unit_clk_en) ##1 (mode == $past(next_mode, 2)
		|| $past(next_mode) != $past(mode)))
		else $error("enables moved before mode edge");

	irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(irq_status & irq_mask) |=> irq)
		else $error("interrupt missing");

	read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_phase && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	deep_entry_c: cover property (@(posedge hclk) disable iff (!hresetn)
		events[IRQ_ENTER_BIT] && auto_gating_select);
	fault_c: cover property (@(posedge hclk) disable iff (!hresetn) bus_fault);
	ds_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
		rd_wait && ph_addr == DS_GATE_OFS);
	wr_then_rd_c: cover property (@(posedge hclk) disable iff (!hresetn)
		wr_hit(wr_now, ph_addr, DS_GATE_OFS) ##1 rd_wait);
endmodule

// file: src/gate_pkg.sv
// Purpose: Shared constants and types of the peripheral clock-gating block
// Assumes: 32-bit AHB-Lite register bus, one system clock
// Notes:   Offsets are byte addresses within the block
package gate_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [11:0] CLK_CFG_OFS    = 12'h060;
	localparam logic [11:0] RUN_GATE_OFS   = 12'h100;
	localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
	localparam logic [11:0] DS_GATE_OFS    = 12'h124;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h200;
	localparam logic [11:0] IRQ_MASK_OFS   = 12'h204;
	localparam logic [11:0] FAULT_SEEN_OFS = 12'h208;
	localparam logic [11:0] GATE_STATE_OFS = 12'h20c;

	// ************************************************************
	// Gate field positions
	// ************************************************************
	localparam int COMPARATOR0_GATE_BIT         = 24;
	localparam int GP_A_BIT          = 19;
	localparam int GP_B_BIT          = 18;
	localparam int GP_C_BIT          = 17;
	localparam int GP_D_BIT          = 16;
	localparam int TWO_WIRE0_BIT     = 12;
	localparam int SYNC_SERIAL1_BIT  = 5;
	localparam int SYNC_SERIAL0_BIT  = 4;
	localparam int ASYNC_SERIAL2_BIT = 2;
	localparam int ASYNC_SERIAL1_BIT = 1;
	localparam int ASYNC_SERIAL0_BIT = 0;

	localparam logic [31:0] GATE_WRITABLE =
		(32'h1 << COMPARATOR0_GATE_BIT) | (32'h1 << GP_A_BIT) | (32'h1 << GP_B_BIT) |
		(32'h1 << GP_C_BIT) | (32'h1 << GP_D_BIT) | (32'h1 << TWO_WIRE0_BIT) |
		(32'h1 << SYNC_SERIAL1_BIT) | (32'h1 << SYNC_SERIAL0_BIT) |
		(32'h1 << ASYNC_SERIAL2_BIT) | (32'h1 << ASYNC_SERIAL1_BIT) |
		(32'h1 << ASYNC_SERIAL0_BIT);

	// ************************************************************
	// Reset values and other fields
	// ************************************************************
	localparam logic [31:0] GATE_RESET      = 32'h0000_0000;
	localparam logic        CFG_RESET       = 1'b0;
	localparam int          AUTO_GATING_BIT = 0;
	localparam int          HTRANS_ACT_BIT  = 1;
	localparam int          IRQ_WIDTH       = 3;
	localparam int          IRQ_FAULT_BIT   = 0;
	localparam int          IRQ_ENTER_BIT   = 1;
	localparam int          IRQ_EXIT_BIT    = 2;
	localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

	typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep} mode_t;

endpackage

// file: src/gate_if.sv
// Purpose: Carrier between gating top, selector and fault checker
// Assumes: All signals in the hclk domain
// Notes:   No clocking block
`timescale 1ns/1ps
interface gate_if import gate_pkg::*; ();
	logic [31:0] run_gate;
	logic [31:0] sleep_gate;
	logic [31:0] deep_gate;
	logic        auto_gating;
	mode_t       mode;
	logic [31:0] clk_en;
	logic [31:0] access;
	logic        fault;
	logic [31:0] fault_vec;

	modport top (output run_gate, sleep_gate, deep_gate, auto_gating, mode, access,
		input clk_en, fault, fault_vec);
	modport sel (input run_gate, sleep_gate, deep_gate, auto_gating, mode,
		output clk_en);
	modport chk (input clk_en, access, output fault, fault_vec);
endinterface

// file: src/gate_select.sv
// Purpose: Picks the gating register for the power mode, registered
// Assumes: Mode and registers in the hclk domain
// Notes:   Enables change only at a clock edge, or at once when hresetn falls
`timescale 1ns/1ps
module gate_select import gate_pkg::*; (
	input  wire logic hclk,
	input  wire logic hresetn,
	gate_if.sel       gi
);
	// ************************************************************
	// Registered selection
	// ************************************************************
	logic [31:0] next_clk_en;

	always_comb begin
		next_clk_en = gi.run_gate;
		unique case (gi.mode)
			mode_run: next_clk_en = gi.run_gate;
			mode_sleep: next_clk_en = gi.auto_gating ? gi.sleep_gate : gi.run_gate;
			mode_deep: next_clk_en = gi.auto_gating ? gi.deep_gate : gi.run_gate;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gi.clk_en <= GATE_RESET;
		end else begin
			gi.clk_en <= next_clk_en & GATE_WRITABLE;
		end
	end
endmodule

// file: src/fault_check.sv
// Purpose: Flags bus accesses aimed at unclocked units
// Assumes: One access strobe bit per gate position
// Notes:   Fault is a registered level that follows the access one cycle later
`timescale 1ns/1ps
module fault_check import gate_pkg::*; (
	input  wire logic hclk,
	input  wire logic hresetn,
	gate_if.chk       gi
);
	// ************************************************************
	// Fault detection
	// ************************************************************
	logic [31:0] hit;

	assign hit = gi.access & GATE_WRITABLE & ~gi.clk_en;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gi.fault     <= 1'b0;
			gi.fault_vec <= 32'h0000_0000;
		end else begin
			gi.fault     <= |hit;
			gi.fault_vec <= hit;
		end
	end
endmodule

// file: testbench/tb_top.sv
// Purpose: Self-checking bench of the bank 1 peripheral clock-gating block
// Assumes: One slave on the AHB-Lite bus, hready tied to hreadyout
// Notes:   Monitor compares bus reads and fault pulses against queued notes
`timescale 1ns/1ps
module tb_top import gate_pkg::*;;

	// ************************************************************
	// Signals
	// ************************************************************
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        sleep_mode;
	logic        deep_sleep_mode;
	logic [31:0] unit_access;
	logic [31:0] unit_clk_en;
	logic        bus_fault;
	logic        irq;
	int          n_mismatch = 0;
	int          num_checks = 0;
	logic [31:0] rq[$];
	logic        fq[$];
	logic        rd_ph = 1'b0;
	logic        acc_d1 = 1'b0;
	logic [31:0] run_v;
	logic [31:0] slp_v;
	logic [31:0] dp_v;
	logic [31:0] exp_en;

	assign hready = hreadyout;

	deep_sleep_clock_gate_reg1 uut (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.hsel            (hsel),
		.haddr           (haddr),
		.htrans          (htrans),
		.hwrite          (hwrite),
		.hsize           (hsize),
		.hwdata          (hwdata),
		.hready          (hready),
		.hrdata          (hrdata),
		.hreadyout       (hreadyout),
		.hresp           (hresp),
		.sleep_mode      (sleep_mode),
		.deep_sleep_mode (deep_sleep_mode),
		.unit_access     (unit_access),
		.unit_clk_en     (unit_clk_en),
		.bus_fault       (bus_fault),
		.irq             (irq)
	);

	initial hclk = 1'b0;
	always #2 hclk = ~hclk;

	// ************************************************************
	// Compare and closing tasks
	// ************************************************************
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task results;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ************************************************************
	// Drivers
	// ************************************************************
	task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		rq.push_back(e);
		ahb(1'b0, a, 32'h0);
	endtask

	task mode_chk(input logic s, input logic d, input logic [31:0] e);
		@(posedge hclk);
		sleep_mode <= s;
		deep_sleep_mode <= d;
		repeat (2) @(posedge hclk);
		chk_word(unit_clk_en, exp_en);
		@(posedge hclk);
		chk_word(unit_clk_en, e);
		exp_en = e;
	endtask

	task poke(input logic [31:0] v, input logic [31:0] en);
		fq.push_back(|(v & ~en & GATE_WRITABLE));
		@(posedge hclk);
		unit_access <= v;
		@(posedge hclk);
		unit_access <= 32'h0;
	endtask

	// ************************************************************
	// Monitor
	// ************************************************************
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			if (rq.size() == 0)
				chk_bit(1'b1, 1'b0);
			else
				chk_word(hrdata, rq.pop_front());
			chk_bit(hresp, 1'b0);
		end
		if (acc_d1)
			chk_bit(bus_fault, fq.pop_front());
		else if (hresetn === 1'b1)
			chk_bit(bus_fault, 1'b0);
		if (hreadyout === 1'b1)
			rd_ph <= hsel && htrans[1] && !hwrite;
		acc_d1 <= unit_access != 32'h0;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		hresetn = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		sleep_mode = 1'b0;
		deep_sleep_mode = 1'b0;
		unit_access = 32'h0;
		exp_en = 32'h0;
		void'($urandom(32'h0e90));
		#1;
		hresetn = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(DS_GATE_OFS, GATE_RESET);
		chk_word(unit_clk_en, 32'h0);
		for (int i = 0; i < 32; i++) begin
			wr(DS_GATE_OFS, 32'h1 << i);
			rd(DS_GATE_OFS, (32'h1 << i) & GATE_WRITABLE);
		end
		wr(DS_GATE_OFS, 32'hffff_ffff);
		rd(DS_GATE_OFS, GATE_WRITABLE);
		wr(12'h3fc, 32'hffff_ffff);
		rd(12'h3fc, 32'h0);
		rd(12'h125, 32'h0);
		for (int k = 0; k < 4; k++) begin
			run_v = $urandom;
			slp_v = $urandom;
			dp_v = $urandom;
			wr(CLK_CFG_OFS, 32'h0);
			wr(RUN_GATE_OFS, run_v);
			wr(SLEEP_GATE_OFS, slp_v);
			wr(DS_GATE_OFS, dp_v);
			exp_en = run_v & GATE_WRITABLE;
			mode_chk(1'b0, 1'b0, run_v & GATE_WRITABLE);
			mode_chk(1'b0, 1'b1, run_v & GATE_WRITABLE);
			mode_chk(1'b1, 1'b0, run_v & GATE_WRITABLE);
			mode_chk(1'b0, 1'b0, run_v & GATE_WRITABLE);
			wr(CLK_CFG_OFS, 32'h1);
			rd(CLK_CFG_OFS, 32'h1);
			mode_chk(1'b1, 1'b0, slp_v & GATE_WRITABLE);
			mode_chk(1'b1, 1'b1, dp_v & GATE_WRITABLE);
			wr(GATE_STATE_OFS, 32'hffff_ffff);
			rd(GATE_STATE_OFS, dp_v & GATE_WRITABLE);
			mode_chk(1'b0, 1'b0, run_v & GATE_WRITABLE);
			for (int j = 0; j < 8; j++)
				poke($urandom | 32'h8, run_v);
		end
		poke(~GATE_WRITABLE, 32'h0);
		wr(CLK_CFG_OFS, 32'h0);
		wr(RUN_GATE_OFS, 32'h0);
		exp_en = 32'h0;
		mode_chk(1'b0, 1'b0, 32'h0);
		wr(IRQ_MASK_OFS, 32'h0);
		wr(IRQ_STATUS_OFS, 32'h7);
		rd(IRQ_STATUS_OFS, 32'h0);
		poke(GATE_WRITABLE, 32'h0);
		rd(IRQ_STATUS_OFS, 32'h1);
		rd(FAULT_SEEN_OFS, GATE_WRITABLE);
		chk_bit(irq, 1'b0);
		wr(IRQ_MASK_OFS, 32'h1);
		repeat (3) @(posedge hclk);
		chk_bit(irq, 1'b1);
		wr(IRQ_STATUS_OFS, 32'h1);
		repeat (3) @(posedge hclk);
		chk_bit(irq, 1'b0);
		wr(IRQ_MASK_OFS, 32'h7);
		rd(IRQ_MASK_OFS, 32'h7);
		mode_chk(1'b0, 1'b1, 32'h0);
		mode_chk(1'b0, 1'b0, 32'h0);
		rd(IRQ_STATUS_OFS, 32'h6);
		chk_bit(irq, 1'b1);
		wr(IRQ_STATUS_OFS, 32'h6);
		rd(IRQ_STATUS_OFS, 32'h0);
		wr(RUN_GATE_OFS, 32'hffff_ffff);
		wr(DS_GATE_OFS, 32'hffff_ffff);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(DS_GATE_OFS, GATE_RESET);
		rd(RUN_GATE_OFS, GATE_RESET);
		chk_word(unit_clk_en, 32'h0);
		repeat (2) @(posedge hclk);
		results;
	end

	// ************************************************************
	// Watchdog
	// ************************************************************
	initial begin
		#200000;
		n_mismatch++;
		results;
	end

endmodule
